// *** bench/socket_status_change_events_tb.sv ***
// Self-checking bench for the socket status-change event block.
// Assumes ssce_top, its bound checker and the socket pin model.
`timescale 1ns/1ps
module socket_status_change_events_tb
    import ssce_pkg::*;
;
    localparam logic [7:0] FL = SSCE_FLAGS_OFFSET;
    localparam logic [7:0] EN = SSCE_ENABLE_OFFSET;
    localparam logic [7:0] PR = SSCE_PRESENT_OFFSET;
    logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, status_irq;
    logic aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, card_in = 1'h0, stschg = 1'h0, pwr = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, bs, rs;
    logic card_detect1_n, card_detect2_n, card_status_change, power_cycle_done;
    int err_count = 0;
    int total_checks = 0;
    ssce_top i_dut (.*);
    ssce_socket_model i_pins (.*);
    // Free-running 200 MHz clock
    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end
    // ----
    // Bus and check helpers
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic hang();
        $display("CHECK FAILED at %0t: no bus answer", $time);
        err_count++;
        print_verdict();
    endtask
    // Offers address and data together, releases each once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        bs = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n == 40) hang();
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n == 40) hang();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
        chk(rs, SSCE_RESP_OKAY);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic pins(input logic c, input logic s, input logic p);
        @(posedge aclk);
        card_in <= c;
        stschg <= s;
        pwr <= p;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_basic();
        rdc(FL, 32'h0);
        rdc(EN, 32'h0);
        rdc(PR, 32'h6);
        wr(EN, 32'hFFFFFFFF);
        rdc(EN, 32'hF);
        chk(status_irq, 1'h0);
        wr(EN, 32'h0);
        rdc(EN, 32'h0);
        wr(8'h14, 32'hF);
        chk(bs, SSCE_RESP_SLVERR);
        rdc(EN, 32'h0);
        s_axi_wstrb <= 4'hE;
        wr(EN, 32'hF);
        chk(bs, SSCE_RESP_OKAY);
        rdc(EN, 32'h0);
        s_axi_wstrb <= 4'hF;
        rdr(8'h10);
        chk(rd, 32'h0);
        chk(rs, SSCE_RESP_SLVERR);
        $display("test basic done");
    endtask
    task automatic t_insert();
        pins(1'h1, 1'h0, 1'h0);
        idle(6);
        rdc(FL, 32'h2);
        idle(12);
        rdc(FL, 32'h6);
        rdc(PR, 32'h0);
        wr(EN, 32'h2);
        idle(3);
        chk(status_irq, 1'h0);
        wr(EN, 32'h4);
        idle(3);
        chk(status_irq, 1'h0);
        wr(EN, 32'h6);
        idle(3);
        chk(status_irq, 1'h1);
        wr(FL, 32'h6);
        rdc(FL, 32'h0);
        chk(status_irq, 1'h0);
        $display("test insert done");
    endtask
    task automatic t_events();
        wr(EN, 32'h1);
        pins(1'h1, 1'h1, 1'h1);
        idle(6);
        rdc(FL, 32'h9);
        chk(status_irq, 1'h1);
        wr(EN, 32'h0);
        idle(3);
        chk(status_irq, 1'h0);
        wr(EN, 32'h8);
        idle(3);
        chk(status_irq, 1'h1);
        wr(FL, 32'h9);
        pins(1'h1, 1'h0, 1'h0);
        idle(6);
        rdc(FL, 32'h1);
        chk(status_irq, 1'h0);
        wr(EN, 32'h9);
        idle(2);
        chk(status_irq, 1'h1);
        pins(1'h0, 1'h0, 1'h0);
        idle(20);
        rdc(EN, 32'h8);
        chk(status_irq, 1'h0);
        rdc(FL, 32'h7);
        $display("test events done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset, then each scenario in turn
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_basic();
        t_insert();
        t_events();
        print_verdict();
    end
endmodule

// *** bench/ssce_socket_model.sv ***
// Socket pin model: detect contacts, status pin, power done.
// Assumes requests change just after rising edges of aclk.
`timescale 1ns/1ps
module ssce_socket_model #(
    parameter int LAG = 10
) (
    input wire logic aclk,
    input wire logic card_in,
    input wire logic stschg,
    input wire logic pwr,
    output logic card_detect1_n,
    output logic card_detect2_n,
    output logic card_status_change,
    output logic power_cycle_done
);
    logic [15:0] hist = 16'h0000;
    // Second contact mates later, as on a slow insertion
    always_ff @(posedge aclk) begin
        hist <= {hist[14:0], card_in};
    end
    // Detect pins pulled high while no card sits in the socket
    assign card_detect1_n = !card_in;
    assign card_detect2_n = !hist[LAG-1];
    assign card_status_change = stschg;
    assign power_cycle_done = pwr;
endmodule

// *** bench/ssce_top_props.sv ***
// Checker on the read path, write answer and request line.
// Assumes it is bound into ssce_top and sees only its ports.
`timescale 1ns/1ps
module ssce_top_props
    import ssce_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic status_irq
);
    // ----
    // Read address tracking
    // ----
    logic [7:0] ra;
    wire is_fl = (ra == SSCE_FLAGS_OFFSET);
    wire is_en = (ra == SSCE_ENABLE_OFFSET);
    wire mapped = is_fl || is_en || (ra == SSCE_PRESENT_OFFSET);
    // Address of the read in flight, to judge its data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ra <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ra <= s_axi_araddr;
        end
    end
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----
    // Properties
    // ----
    property p_irq_rst; $rose(aresetn) |-> !status_irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("request high after reset");
    property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_once: assert property (p_r_once) else $error("read answer repeated");
    property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar_ans: assert property (p_ar_ans) else $error("read not answered");
    property p_en_up; s_axi_rvalid && is_en |-> s_axi_rdata[31:4] == 28'h0; endproperty
    a_en_up: assert property (p_en_up) else $error("enable upper bits set");
    property p_fl_up; s_axi_rvalid && is_fl |-> s_axi_rdata[31:4] == 28'h0; endproperty
    a_fl_up: assert property (p_fl_up) else $error("flag upper bits set");
    property p_err; s_axi_rvalid && !mapped |-> s_axi_rdata == 32'h0 && s_axi_rresp == SSCE_RESP_SLVERR; endproperty
    a_err: assert property (p_err) else $error("unmapped read answer");
    property p_ok; s_axi_rvalid && mapped |-> s_axi_rresp == SSCE_RESP_OKAY; endproperty
    a_ok: assert property (p_ok) else $error("mapped read refused");
endmodule
bind ssce_top ssce_top_props i_props (.*);

// *** rtl/ssce_pin_sync.sv ***
// Two-stage synchroniser with change detect for one socket pin.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/1ps
module ssce_pin_sync
    import ssce_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_async,
    input wire logic reset_level,
    output logic level,
    output logic changed
);
    logic meta;
    logic sync;
    logic [1:0] settle;

    // ------------------------------------------------------------
    // Synchroniser; only the second stage is looked at
    // ------------------------------------------------------------
    // Level holds the assumed idle value until real pin data has
    // reached the second stage, so reset leaves no false edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            settle <= 2'b00;
            level <= reset_level;
        end else begin
            meta <= pin_async;
            sync <= meta;
            settle <= {settle[0], 1'b1};
            if (settle[1]) begin
                level <= sync;
            end
        end
    end

    // Change only after the pipe has settled, so reset is no event
    assign changed = settle[1] && (sync != level);
endmodule

// *** rtl/ssce_pkg.sv ***
// Constants for the socket status-change event block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package ssce_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SSCE_FLAGS_OFFSET = 8'h00;
    localparam logic [7:0] SSCE_ENABLE_OFFSET = 8'h04;
    localparam logic [7:0] SSCE_PRESENT_OFFSET = 8'h08;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SSCE_BIT_STSCHG = 0;
    localparam int SSCE_BIT_DETECT1 = 1;
    localparam int SSCE_BIT_DETECT2 = 2;
    localparam int SSCE_BIT_PWR_DONE = 3;
    localparam int SSCE_EVENT_BITS = 4;

    // ------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------
    localparam logic [3:0] SSCE_FLAGS_RESET = 4'h0;
    localparam logic [3:0] SSCE_ENABLE_RESET = 4'h0;
    localparam logic [1:0] SSCE_DETECT_EN_ALL = 2'h3;
    localparam logic [1:0] SSCE_RESP_OKAY = 2'h0;
    localparam logic [1:0] SSCE_RESP_SLVERR = 2'h2;
endpackage

// *** rtl/ssce_top.sv ***
// Socket status-change event register, interrupt enable and request.
// Assumes an AXI4-Lite master on aclk and asynchronous socket pins.
// What this block does
// - Power-cycle done pulse sets event bit three.
// - Event bits clear on write one, reset zero.
// - Detect-two pin change sets event bit two.
// - Detect-one pin change sets event bit one.
// - Status-change pin change sets event bit zero.
// - Interrupt request comes from event register bits.
// - Power-cycle enable zero blocks its interrupt.
// - Writing one to enable bit sets it.
// - Detect enable field: 00 blocks, 11 allows.
// - Detect masking blocks interrupt, not event bits.
// - Status-change enable zero blocks its interrupt.
// - Status-change enable clears on removal, reset.
// - Enable register upper bits read zero.
// - Detect state reads one when pin high.
`timescale 1ns/1ps
module ssce_top
    import ssce_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic card_detect1_n,
    input wire logic card_detect2_n,
    input wire logic card_status_change,
    input wire logic power_cycle_done,
    output logic status_irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic det1_level;
    logic det1_changed;
    logic det2_level;
    logic det2_changed;
    logic stschg_level;
    logic stschg_changed;
    logic pwr_meta;
    logic pwr_sync;
    logic pwr_prev;

    // Each pin crosses into aclk through two flops; logic only ever
    // reads the second stage
    // Detect pins idle high (no card) so reset assumes empty socket
    ssce_pin_sync u_det1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(card_detect1_n),
        .reset_level(1'b1),
        .level(det1_level),
        .changed(det1_changed)
    );

    ssce_pin_sync u_det2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(card_detect2_n),
        .reset_level(1'b1),
        .level(det2_level),
        .changed(det2_changed)
    );

    ssce_pin_sync u_stschg (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(card_status_change),
        .reset_level(1'b0),
        .level(stschg_level),
        .changed(stschg_changed)
    );

    // Power sequencer lives elsewhere; its done level is synchronised here
    // Rising edge only: a done level held high raises one event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_meta <= 1'b0;
            pwr_sync <= 1'b0;
            pwr_prev <= 1'b0;
        end else begin
            pwr_meta <= power_cycle_done;
            pwr_sync <= pwr_meta;
            pwr_prev <= pwr_sync;
        end
    end

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    logic [3:0] event_set;
    logic card_removed;

    // Each source is a one-cycle pulse on aclk. A pin that toggles
    // faster than the synchroniser can follow may merge two changes
    // into one event; software sees a single flag either way.
    // Done rises once per cycle, success or not; software reads the
    // socket state word to learn whether power came up
    assign event_set[SSCE_BIT_PWR_DONE] = pwr_sync && !pwr_prev;
    assign event_set[SSCE_BIT_DETECT2] = det2_changed;
    assign event_set[SSCE_BIT_DETECT1] = det1_changed;
    assign event_set[SSCE_BIT_STSCHG] = stschg_changed;
    // Removal: a detect pin going from low to high
    assign card_removed = (det1_changed && !det1_level) || (det2_changed && !det2_level);

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_fire;
    logic wr_flags;
    logic wr_enable;
    logic wr_known;
    logic aw_fire;
    logic w_fire;
    logic [1:0] wr_resp;

    // Channel handshakes; each half is taken on its own
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    // Readies drop while a response waits, so a second write cannot
    // overwrite the held halves before the first one has acted;
    // this costs throughput, which a status block does not need
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign write_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_flags = write_fire && (aw_addr[7:2] == SSCE_FLAGS_OFFSET[7:2]) && w_strb[0];
    assign wr_enable = write_fire && (aw_addr[7:2] == SSCE_ENABLE_OFFSET[7:2]) && w_strb[0];
    assign wr_known = (aw_addr[7:2] == SSCE_FLAGS_OFFSET[7:2]) ||
                      (aw_addr[7:2] == SSCE_ENABLE_OFFSET[7:2]) ||
                      (aw_addr[7:2] == SSCE_PRESENT_OFFSET[7:2]);
    // Writes to the read-only state word are accepted and dropped
    assign wr_resp = wr_known ? SSCE_RESP_OKAY : SSCE_RESP_SLVERR;

    // Address and data captured independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (write_fire) begin
                aw_held <= 1'b0;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (write_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response one cycle after both halves are held
    // Response holds until bready; readies stay low meanwhile
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SSCE_RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Event flags and enables
    // ------------------------------------------------------------
    logic [3:0] flags;
    logic [3:0] enable;
    logic [3:0] flag_clear;
    logic [3:0] next_flags;
    logic [3:0] next_enable;

    // Write one clears, but a same-cycle event wins, so a change that
    // lands while software clears the old one is never lost
    assign flag_clear = wr_flags ? w_data[3:0] : 4'h0;
    assign next_flags = (flags & ~flag_clear) | event_set;

    // Plain write; removal forces the status-change enable low
    // Removal beats a same-cycle write, so the enable cannot survive a pull
    always_comb begin
        next_enable = enable;
        if (wr_enable) begin
            next_enable = w_data[3:0];
        end
        if (card_removed) begin
            next_enable[SSCE_BIT_STSCHG] = 1'b0;
        end
    end

    // One register stage for flags and enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= SSCE_FLAGS_RESET;
            enable <= SSCE_ENABLE_RESET;
        end else begin
            flags <= next_flags;
            enable <= next_enable;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    logic detect_allowed;
    logic [3:0] pending;

    // Masking acts on the request only; the flags themselves stay
    // visible so software can still poll the socket
    // Only 11 opens detect events; 01 and 10 are treated as blocked
    assign detect_allowed = (enable[SSCE_BIT_DETECT2:SSCE_BIT_DETECT1] == SSCE_DETECT_EN_ALL);
    assign pending[SSCE_BIT_STSCHG] = flags[SSCE_BIT_STSCHG] && enable[SSCE_BIT_STSCHG];
    assign pending[SSCE_BIT_DETECT1] = flags[SSCE_BIT_DETECT1] && detect_allowed;
    assign pending[SSCE_BIT_DETECT2] = flags[SSCE_BIT_DETECT2] && detect_allowed;
    assign pending[SSCE_BIT_PWR_DONE] = flags[SSCE_BIT_PWR_DONE] && enable[SSCE_BIT_PWR_DONE];

    // Registered so the pin is glitch free
    // Costs one cycle of latency after a flag or enable changes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_irq <= 1'b0;
        end else begin
            status_irq <= |pending;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [31:0] read_word;
    logic read_known;
    logic [31:0] present_word;
    logic rd_fire;
    logic [1:0] rd_resp;

    // Socket state: detect levels read as pins, 1 = no card
    assign present_word = {28'h000_0000, pwr_sync, det2_level, det1_level, stschg_level};
    assign read_known = (s_axi_araddr[7:2] == SSCE_FLAGS_OFFSET[7:2]) ||
                        (s_axi_araddr[7:2] == SSCE_ENABLE_OFFSET[7:2]) ||
                        (s_axi_araddr[7:2] == SSCE_PRESENT_OFFSET[7:2]);
    always_comb begin
        read_word = 32'h0000_0000;
        if (s_axi_araddr[7:2] == SSCE_FLAGS_OFFSET[7:2]) begin
            read_word = {28'h000_0000, flags};
        end else if (s_axi_araddr[7:2] == SSCE_ENABLE_OFFSET[7:2]) begin
            read_word = {28'h000_0000, enable};
        end else if (s_axi_araddr[7:2] == SSCE_PRESENT_OFFSET[7:2]) begin
            read_word = present_word;
        end
    end

    // One read in flight; the address is refused while data waits
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    // Unmapped words answer with an error and zero data
    assign rd_resp = read_known ? SSCE_RESP_OKAY : SSCE_RESP_SLVERR;

    // Data captured at address acceptance, held until taken
    // A flag that sets while rvalid waits shows on the next read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SSCE_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= rd_resp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
